// ### hw/mfm_pkg.sv
// constants shared by the motor driver fault manager and its helpers
// assumes a single 250 MHz clock; all times below are turned into cycle counts here
package mfm_pkg;
  localparam int CLK_MHZ = 250;
  localparam int CLK_KHZ = 250000;
  localparam int SW_N = 6;
  localparam int HALL_N = 3;
  localparam int TMR_W = 32;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;

  // register byte offsets
  localparam logic [ADR_W-1:0] ADR_CFG = 8'h00;
  localparam logic [ADR_W-1:0] ADR_CTRL = 8'h04;
  localparam logic [ADR_W-1:0] ADR_STAT = 8'h08;

  // config and control register fields
  localparam int CFG_OVERVOLT_PROTECT_EN = 0;
  localparam int CFG_OVERVOLT_THRESHOLD_SEL = 1;
  localparam int CFG_OVERCURRENT_RESPONSE_SEL = 2;
  localparam int CFG_OVERCURRENT_LEVEL_SEL = 4;
  localparam int CFG_OVERCURRENT_DEGLITCH_SEL = 5;
  localparam int CFG_LOCK_MODE = 6;
  localparam int CFG_LOCK_TDET = 8;
  localparam int CFG_THERMAL_WARN_REPORT_EN = 10;
  localparam int CTRL_CLR = 0;

  // chip status register fields
  localparam int ST_FAULT = 0;
  localparam int ST_PUMP_UV = 1;
  localparam int ST_OVP = 2;
  localparam int ST_OCP = 3;
  localparam int ST_REG_FAULT = 4;
  localparam int ST_REG_OC = 5;
  localparam int ST_STALL = 6;
  localparam int ST_TEMP = 7;
  localparam int ST_OTW = 8;
  localparam int ST_OTS = 9;
  localparam int ST_SERIAL = 10;
  localparam int ST_OCP_SW = 12;

  // response selections, shared by overcurrent and stall
  localparam logic [1:0] RSP_LATCH = 2'h0;
  localparam logic [1:0] RSP_RETRY = 2'h1;
  localparam logic [1:0] RSP_REPORT = 2'h2;
  localparam logic [1:0] RSP_OFF = 2'h3;

  // times as specified, then cycles (least times round up)
  localparam int OVERCURRENT_DEGLITCH_SEL_A_NS = 600;
  localparam int OVERCURRENT_DEGLITCH_SEL_B_NS = 1200;
  localparam int REG_DEG_NS = 1000;
  localparam int OCP_RETRY_US = 5000;
  localparam int REG_RETRY_US = 5000;
  localparam int LOCK_RETRY_MS = 5000;
  localparam int LOCK_HW_MS = 1000;
  localparam int LOCK_T0_MS = 300;
  localparam int LOCK_T1_MS = 500;
  localparam int LOCK_T2_MS = 1000;
  localparam int LOCK_T3_MS = 5000;
  localparam int RST_MAX_US = 20;
  localparam int OVERCURRENT_DEGLITCH_SEL_A_CYC = (OVERCURRENT_DEGLITCH_SEL_A_NS * CLK_MHZ + 999) / 1000;
  localparam int OVERCURRENT_DEGLITCH_SEL_B_CYC = (OVERCURRENT_DEGLITCH_SEL_B_NS * CLK_MHZ + 999) / 1000;
  localparam int REG_DEG_CYC = (REG_DEG_NS * CLK_MHZ + 999) / 1000;
  localparam int OCP_RETRY_CYC = OCP_RETRY_US * CLK_MHZ;
  localparam int REG_RETRY_CYC = REG_RETRY_US * CLK_MHZ;
  localparam int LOCK_RETRY_CYC = LOCK_RETRY_MS * CLK_KHZ;
  localparam int LOCK_HW_CYC = LOCK_HW_MS * CLK_KHZ;
  localparam int LOCK_T0_CYC = LOCK_T0_MS * CLK_KHZ;
  localparam int LOCK_T1_CYC = LOCK_T1_MS * CLK_KHZ;
  localparam int LOCK_T2_CYC = LOCK_T2_MS * CLK_KHZ;
  localparam int LOCK_T3_CYC = LOCK_T3_MS * CLK_KHZ;
  localparam int RST_MAX_CYC = RST_MAX_US * CLK_MHZ;

  // timer slots
  localparam int TMR_OCP = 0;
  localparam int TMR_REG = 1;
  localparam int TMR_LOCK = 2;
  localparam int TMR_OCPR = 3;
  localparam int TMR_LOCKR = 4;
  localparam int TMR_REGR = 5;
  localparam int TMR_SLP = 6;
  localparam int TMR_N = 7;

  localparam logic [1:0] STRAP_WAIT = 2'h3;

  typedef enum logic [2:0] {
    SLP_AWAKE = 3'b001,
    SLP_LOW = 3'b010,
    SLP_ASLEEP = 3'b100
  } mfm_slp_e;
endpackage

// ### hw/mfm_tmr_if.sv
// run/limit/expired bundle between the fault manager and one interval timer
// assumes both ends share clk_i
`timescale 1ns/1ns
`default_nettype none
interface mfm_tmr_if;
  logic run;
  logic [mfm_pkg::TMR_W-1:0] limit;
  logic expired;
  modport ctl (output run, output limit, input expired);
  modport tmr (input run, input limit, output expired);
endinterface
`default_nettype wire

// ### hw/mfm_sync.sv
// two-flop synchroniser for a vector of asynchronous pins
// assumes each bit is an independent level; no bus coherence is implied
`timescale 1ns/1ns
`default_nettype none
module mfm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mfm_sync_s;

  mfm_sync_s s_q;
  mfm_sync_s s_d;

  // first stage feeds only the second
  always_comb
  begin
    s_d.s1 = d_i;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '{s1: RST_VAL, s2: RST_VAL};
    end
    else if (ce_i)
    begin
      s_q <= s_d;
    end
  end

  assign q_o = s_q.s2;
endmodule // mfm_sync
`default_nettype wire

// ### hw/mfm_timer.sv
// interval counter: expired rises after limit consecutive cycles of run
// assumes limit >= 1; dropping run restarts the count from zero
`timescale 1ns/1ns
`default_nettype none
module mfm_timer
  import mfm_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // control
  mfm_tmr_if.tmr bus
);
  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic exp;
  } mfm_tmr_s;

  mfm_tmr_s s_q;
  mfm_tmr_s s_d;

  always_comb
  begin
    s_d = '0;
    if (bus.run)
    begin
      s_d.cnt = (s_q.cnt == '1) ? s_q.cnt : s_q.cnt + 1'b1;
      s_d.exp = (s_q.cnt >= bus.limit - 1'b1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else if (ce_i)
    begin
      s_q <= s_d;
    end
  end

  assign bus.expired = s_q.exp;
endmodule // mfm_timer
`default_nettype wire

// ### hw/mfm_fault_mgr.sv
// fault manager of a three-phase motor driver with a wishbone register port
// assumes comparator pins are asynchronous and hysteresis lives in the analog monitors
`timescale 1ns/1ns
`default_nettype none

module mfm_fault_mgr
  import mfm_pkg::*;
#(
  parameter int unsigned OCP_RETRY_CYC_P = mfm_pkg::OCP_RETRY_CYC,
  parameter int unsigned REG_RETRY_CYC_P = mfm_pkg::REG_RETRY_CYC,
  parameter int unsigned LOCK_RETRY_CYC_P = mfm_pkg::LOCK_RETRY_CYC,
  parameter int unsigned LOCK_HW_CYC_P = mfm_pkg::LOCK_HW_CYC,
  parameter int unsigned LOCK_T0_CYC_P = mfm_pkg::LOCK_T0_CYC,
  parameter int unsigned LOCK_T1_CYC_P = mfm_pkg::LOCK_T1_CYC,
  parameter int unsigned LOCK_T2_CYC_P = mfm_pkg::LOCK_T2_CYC,
  parameter int unsigned LOCK_T3_CYC_P = mfm_pkg::LOCK_T3_CYC,
  parameter int unsigned RST_MAX_CYC_P = mfm_pkg::RST_MAX_CYC
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [mfm_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [mfm_pkg::DAT_W-1:0] wb_dat_i,
  output logic [mfm_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // pins and monitors
  input wire logic sleep_n_pin_i,
  input wire logic serial_variant_i,
  input wire logic pump_undervolt_i,
  input wire logic ovp_low_trip_i,
  input wire logic ovp_high_trip_i,
  input wire logic [mfm_pkg::SW_N-1:0] oc_low_trip_i,
  input wire logic [mfm_pkg::SW_N-1:0] oc_high_trip_i,
  input wire logic reg_oc_i,
  input wire logic [mfm_pkg::HALL_N-1:0] hall_i,
  input wire logic thermal_warn_i,
  input wire logic tsd_switch_i,
  input wire logic tsd_die_i,
  // power stage enables and fault pin
  output logic switch_en_o,
  output logic pump_en_o,
  output logic reg_en_o,
  output logic fault_out_n_o
);
  typedef struct packed {
    mfm_slp_e slp;
    logic [1:0] strap_cnt;
    logic serial;
    logic overvolt_protect_en;
    logic overvolt_threshold_sel;
    logic [1:0] overcurrent_response_sel;
    logic overcurrent_level_sel;
    logic overcurrent_deglitch_sel;
    logic [1:0] lock_mode;
    logic [1:0] lock_tdet;
    logic thermal_warn_report_en;
    logic f_sum;
    logic f_pump;
    logic f_ovp;
    logic f_ocp;
    logic [SW_N-1:0] f_ocp_sw;
    logic f_reg;
    logic f_reg_oc;
    logic f_stall;
    logic f_temp;
    logic f_otw;
    logic f_ots;
    logic ocp_hold;
    logic ocp_retry;
    logic ocp_rep;
    logic lock_hold;
    logic lock_retry;
    logic lock_rep;
    logic reg_retry;
    logic [HALL_N-1:0] hall_prev;
    logic sw_en;
    logic pump_en;
    logic reg_en;
    logic fault_n;
    logic ack;
    logic [DAT_W-1:0] dat;
  } mfm_state_s;

  localparam mfm_state_s ST_RESET = '{slp: SLP_AWAKE, fault_n: 1'b1, default: '0};
  localparam int SYNC_W = 2 * SW_N + HALL_N + 9;

  mfm_state_s s_q;
  mfm_state_s s_d;

  // synchronised pins
  logic [SYNC_W-1:0] pins_s;
  logic sleep_n_s, serial_s, pump_s, ovp_lo_s, ovp_hi_s, reg_oc_s, otw_s, tsdf_s, tsdd_s;
  logic [SW_N-1:0] oc_lo_s, oc_hi_s;
  logic [HALL_N-1:0] hall_s;

  // sleep input idles high so reset does not look like a sleep request
  mfm_sync #(
    .W(SYNC_W),
    .RST_VAL({1'b1, {(SYNC_W-1){1'b0}}})
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({sleep_n_pin_i, serial_variant_i, pump_undervolt_i, ovp_low_trip_i, ovp_high_trip_i,
          oc_low_trip_i, oc_high_trip_i, reg_oc_i, hall_i, thermal_warn_i, tsd_switch_i,
          tsd_die_i}),
    .q_o(pins_s)
  );
  assign {sleep_n_s, serial_s, pump_s, ovp_lo_s, ovp_hi_s, oc_lo_s, oc_hi_s, reg_oc_s, hall_s,
          otw_s, tsdf_s, tsdd_s} = pins_s;

  // effective configuration; pin variant ignores software settings
  logic ser, awake, ovp_on, ovp_in, oc_any, hall_edge;
  logic [1:0] overcurrent_response_sel_e, lock_mode_e;
  logic [SW_N-1:0] oc_vec;
  logic [TMR_W-1:0] lock_lim;

  assign ser = s_q.serial;
  assign awake = (s_q.slp != SLP_ASLEEP);
  assign overcurrent_response_sel_e = ser ? s_q.overcurrent_response_sel : RSP_LATCH;
  assign lock_mode_e = ser ? s_q.lock_mode : RSP_LATCH;
  assign ovp_on = ~ser | s_q.overvolt_protect_en;
  assign ovp_in = (ser & ~s_q.overvolt_threshold_sel) ? ovp_lo_s : ovp_hi_s;
  assign oc_vec = (ser & ~s_q.overcurrent_level_sel) ? oc_lo_s : oc_hi_s;
  assign oc_any = |oc_vec;
  assign hall_edge = (hall_s != s_q.hall_prev);

  always_comb
  begin
    case (s_q.lock_tdet)
      2'h0: lock_lim = TMR_W'(LOCK_T0_CYC_P);
      2'h1: lock_lim = TMR_W'(LOCK_T1_CYC_P);
      2'h2: lock_lim = TMR_W'(LOCK_T2_CYC_P);
      default: lock_lim = TMR_W'(LOCK_T3_CYC_P);
    endcase
  end

  // interval timers; all stop and clear while asleep
  logic [TMR_N-1:0] run;
  logic [TMR_N-1:0] expd;
  logic [TMR_W-1:0] lim [TMR_N];

  assign run[TMR_OCP] = awake & s_q.sw_en & oc_any & (overcurrent_response_sel_e != RSP_OFF);
  assign run[TMR_REG] = awake & s_q.reg_en & reg_oc_s;
  // any hall transition restarts the stall count
  assign run[TMR_LOCK] = awake & s_q.sw_en & ~hall_edge & ~s_q.lock_rep
                         & (lock_mode_e != RSP_OFF);
  assign run[TMR_OCPR] = awake & s_q.ocp_retry;
  assign run[TMR_LOCKR] = awake & s_q.lock_retry;
  assign run[TMR_REGR] = awake & s_q.reg_retry;
  assign run[TMR_SLP] = (s_q.slp == SLP_LOW);
  assign lim[TMR_OCP] = TMR_W'((ser & s_q.overcurrent_deglitch_sel) ? OVERCURRENT_DEGLITCH_SEL_B_CYC : OVERCURRENT_DEGLITCH_SEL_A_CYC);
  assign lim[TMR_REG] = TMR_W'(REG_DEG_CYC);
  assign lim[TMR_LOCK] = ser ? lock_lim : TMR_W'(LOCK_HW_CYC_P);
  assign lim[TMR_OCPR] = TMR_W'(OCP_RETRY_CYC_P);
  assign lim[TMR_LOCKR] = TMR_W'(LOCK_RETRY_CYC_P);
  assign lim[TMR_REGR] = TMR_W'(REG_RETRY_CYC_P);
  assign lim[TMR_SLP] = TMR_W'(RST_MAX_CYC_P);

  mfm_tmr_if tif [TMR_N] ();

  for (genvar g = 0; g < TMR_N; g++)
  begin : g_tmr
    assign tif[g].run = run[g];
    assign tif[g].limit = lim[g];
    assign expd[g] = tif[g].expired;
    mfm_timer u_tmr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .bus(tif[g])
    );
  end

  // next-state logic
  logic bus_req, cmd_clr, slp_pulse, clr;
  logic pump_act, ovp_act, tsd_any, ocp_evt, reg_evt, lock_evt;
  logic [DAT_W-1:0] cfg_word, stat_word;
  mfm_state_s keep;

  always_comb
  begin
    s_d = s_q;
    keep = s_q;
    bus_req = wb_cyc_i & wb_stb_i & ~s_q.ack;
    cmd_clr = 1'b0;
    slp_pulse = 1'b0;
    cfg_word = '0;
    stat_word = '0;

    // strap sampled once the synchroniser has settled
    if (s_q.strap_cnt != STRAP_WAIT)
    begin
      s_d.strap_cnt = s_q.strap_cnt + 2'h1;
      if (s_q.strap_cnt == STRAP_WAIT - 2'h1)
      begin
        s_d.serial = serial_s;
      end
    end

    // sleep pin: short low is a clear, long low is sleep
    case (s_q.slp)
      SLP_AWAKE:
      begin
        if (!sleep_n_s)
        begin
          s_d.slp = SLP_LOW;
        end
      end
      SLP_LOW:
      begin
        if (sleep_n_s)
        begin
          s_d.slp = SLP_AWAKE;
          slp_pulse = 1'b1;
        end
        else if (expd[TMR_SLP])
        begin
          s_d.slp = SLP_ASLEEP;
        end
      end
      SLP_ASLEEP:
      begin
        if (sleep_n_s)
        begin
          s_d.slp = SLP_AWAKE;
        end
      end
      default:
      begin
        s_d.slp = SLP_AWAKE;
      end
    endcase

    // register port; one wait state, unmapped reads return zero
    cfg_word[CFG_OVERVOLT_PROTECT_EN] = s_q.overvolt_protect_en;
    cfg_word[CFG_OVERVOLT_THRESHOLD_SEL] = s_q.overvolt_threshold_sel;
    cfg_word[CFG_OVERCURRENT_RESPONSE_SEL +: 2] = s_q.overcurrent_response_sel;
    cfg_word[CFG_OVERCURRENT_LEVEL_SEL] = s_q.overcurrent_level_sel;
    cfg_word[CFG_OVERCURRENT_DEGLITCH_SEL] = s_q.overcurrent_deglitch_sel;
    cfg_word[CFG_LOCK_MODE +: 2] = s_q.lock_mode;
    cfg_word[CFG_LOCK_TDET +: 2] = s_q.lock_tdet;
    cfg_word[CFG_THERMAL_WARN_REPORT_EN] = s_q.thermal_warn_report_en;
    stat_word[ST_FAULT] = s_q.f_sum;
    stat_word[ST_PUMP_UV] = s_q.f_pump;
    stat_word[ST_OVP] = s_q.f_ovp;
    stat_word[ST_OCP] = s_q.f_ocp;
    stat_word[ST_REG_FAULT] = s_q.f_reg;
    stat_word[ST_REG_OC] = s_q.f_reg_oc;
    stat_word[ST_STALL] = s_q.f_stall;
    stat_word[ST_TEMP] = s_q.f_temp;
    stat_word[ST_OTW] = s_q.f_otw;
    stat_word[ST_OTS] = s_q.f_ots;
    stat_word[ST_SERIAL] = s_q.serial;
    stat_word[ST_OCP_SW +: SW_N] = s_q.f_ocp_sw;
    s_d.ack = bus_req;
    s_d.dat = '0;
    if (bus_req && wb_we_i)
    begin
      if (wb_adr_i == ADR_CFG && wb_sel_i[0])
      begin
        s_d.overvolt_protect_en = wb_dat_i[CFG_OVERVOLT_PROTECT_EN];
        s_d.overvolt_threshold_sel = wb_dat_i[CFG_OVERVOLT_THRESHOLD_SEL];
        s_d.overcurrent_response_sel = wb_dat_i[CFG_OVERCURRENT_RESPONSE_SEL +: 2];
        s_d.overcurrent_level_sel = wb_dat_i[CFG_OVERCURRENT_LEVEL_SEL];
        s_d.overcurrent_deglitch_sel = wb_dat_i[CFG_OVERCURRENT_DEGLITCH_SEL];
        s_d.lock_mode = wb_dat_i[CFG_LOCK_MODE +: 2];
      end
      if (wb_adr_i == ADR_CFG && wb_sel_i[1])
      begin
        s_d.lock_tdet = wb_dat_i[CFG_LOCK_TDET +: 2];
        s_d.thermal_warn_report_en = wb_dat_i[CFG_THERMAL_WARN_REPORT_EN];
      end
      if (wb_adr_i == ADR_CTRL && wb_sel_i[0])
      begin
        cmd_clr = wb_dat_i[CTRL_CLR];
      end
    end
    else if (bus_req)
    begin
      if (wb_adr_i == ADR_CFG)
      begin
        s_d.dat = cfg_word;
      end
      else if (wb_adr_i == ADR_STAT)
      begin
        s_d.dat = stat_word;
      end
    end

    // conditions and events
    clr = cmd_clr | slp_pulse;
    pump_act = awake & pump_s;
    ovp_act = awake & ovp_on & ovp_in;
    tsd_any = awake & (tsdf_s | tsdd_s);
    ocp_evt = expd[TMR_OCP];
    reg_evt = expd[TMR_REG];
    lock_evt = expd[TMR_LOCK];

    // overcurrent response
    s_d.ocp_hold = (s_q.ocp_hold & ~(clr & ~oc_any))
                   | (ocp_evt & (overcurrent_response_sel_e == RSP_LATCH));
    s_d.ocp_retry = (s_q.ocp_retry & ~expd[TMR_OCPR])
                    | (ocp_evt & (overcurrent_response_sel_e == RSP_RETRY));
    s_d.ocp_rep = (s_q.ocp_rep & ~clr) | (ocp_evt & (overcurrent_response_sel_e == RSP_REPORT));
    // stall response
    s_d.lock_hold = (s_q.lock_hold & ~clr) | (lock_evt & (lock_mode_e == RSP_LATCH));
    s_d.lock_retry = (s_q.lock_retry & ~expd[TMR_LOCKR])
                     | (lock_evt & (lock_mode_e == RSP_RETRY));
    s_d.lock_rep = (s_q.lock_rep & ~clr) | (lock_evt & (lock_mode_e == RSP_REPORT));
    s_d.reg_retry = (s_q.reg_retry & ~expd[TMR_REGR]) | reg_evt;

    // sticky flags; a new event wins over a clear in the same cycle
    s_d.f_pump = (s_q.f_pump & ~clr) | pump_act;
    s_d.f_ovp = (s_q.f_ovp & ~clr) | ovp_act;
    s_d.f_ocp = (s_q.f_ocp & ~clr) | ocp_evt;
    s_d.f_ocp_sw = (s_q.f_ocp_sw & ~{SW_N{clr}}) | ({SW_N{ocp_evt}} & oc_vec);
    s_d.f_reg = (s_q.f_reg & ~expd[TMR_REGR]) | reg_evt;
    s_d.f_reg_oc = (s_q.f_reg_oc & ~expd[TMR_REGR]) | reg_evt;
    s_d.f_stall = (s_q.f_stall & ~clr & ~expd[TMR_LOCKR]) | lock_evt;
    s_d.f_otw = (s_q.f_otw & ~(clr & ~otw_s)) | (awake & otw_s);
    s_d.f_ots = (s_q.f_ots & ~clr) | tsd_any;
    s_d.f_temp = (s_q.f_temp & ~(clr & ~otw_s & ~tsd_any)) | tsd_any | (awake & otw_s);
    // regulator or stall retry expiry drops the summary unless a pump, overvoltage, overcurrent or shutdown flag remains
    s_d.f_sum = (s_q.f_sum & ~clr
                 & ~((expd[TMR_REGR] | expd[TMR_LOCKR])
                     & ~(s_q.f_pump | s_q.f_ovp | s_q.f_ocp | s_q.f_ots)))
                | pump_act | ovp_act | ocp_evt | reg_evt | lock_evt | tsd_any;
    s_d.hall_prev = hall_s;

    // power stage gating, from next state so outputs act with the flags
    s_d.sw_en = awake & ~pump_act & ~ovp_act & ~s_d.ocp_hold & ~s_d.ocp_retry
                & ~s_d.lock_hold & ~s_d.lock_retry & ~tsd_any;
    s_d.pump_en = awake & ~tsd_any;
    s_d.reg_en = awake & ~s_d.reg_retry & ~(awake & tsdd_s);
    s_d.fault_n = ~(pump_act | ovp_act | s_d.ocp_hold | s_d.ocp_retry | s_d.ocp_rep
                    | s_d.lock_hold | s_d.lock_retry | s_d.lock_rep | s_d.reg_retry
                    | tsd_any | (awake & otw_s & ser & s_q.thermal_warn_report_en));

    // asleep: settings and flags back to defaults, bus still answers
    if (s_q.slp == SLP_ASLEEP)
    begin
      keep = s_d;
      s_d = ST_RESET;
      s_d.slp = keep.slp;
      s_d.strap_cnt = keep.strap_cnt;
      s_d.serial = keep.serial;
      s_d.hall_prev = keep.hall_prev;
      s_d.ack = keep.ack;
      s_d.dat = keep.dat;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= ST_RESET;
    end
    else if (ce_i)
    begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
  assign switch_en_o = s_q.sw_en;
  assign pump_en_o = s_q.pump_en;
  assign reg_en_o = s_q.reg_en;
  assign fault_out_n_o = s_q.fault_n;
endmodule // mfm_fault_mgr
`default_nettype wire

// ### test/mfm_host.sv
// host model: hall source and sleep pin
// assumes the bench clock; hall steps every 8 cycles
`timescale 1ns/1ns
`default_nettype none
module mfm_host
(
  // clock
  input wire logic clk_i,
  // rotor running
  input wire logic spin_i,
  // pins
  output logic [2:0] hall_o = 3'h1,
  output logic sleep_n_o = 1'h1
);
  logic [2:0] div_q = 3'h0;
  // steps far shorter than any stall time
  always @(posedge clk_i)
    if (spin_i)
    begin
      div_q <= div_q + 3'h1;
      if (div_q == 3'h7)
        hall_o <= {hall_o[1:0], ~hall_o[2]};
    end
  // low for n cycles, then high again
  task automatic pulse(input int n);
    @(posedge clk_i);
    sleep_n_o <= 1'h0;
    repeat (n) @(posedge clk_i);
    sleep_n_o <= 1'h1;
  endtask
endmodule // mfm_host
`default_nettype wire

// ### test/mfm_fault_mgr_sva.sv
// port checker for the fault manager
// bound to every fault manager instance
`timescale 1ns/1ns
`default_nettype none
module mfm_fault_mgr_sva
#(
  parameter int unsigned RST_MAX_CYC_P = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // pins
  input wire logic sleep_n_pin_i,
  input wire logic serial_variant_i,
  input wire logic pump_undervolt_i,
  input wire logic ovp_high_trip_i,
  input wire logic tsd_switch_i,
  input wire logic tsd_die_i,
  input wire logic switch_en_o,
  input wire logic pump_en_o,
  input wire logic reg_en_o,
  input wire logic fault_out_n_o
);
  logic [15:0] slp_q;
  wire logic aw = sleep_n_pin_i && ce_i;
  // saturates so a long sleep never wraps
  always_ff @(posedge clk_i)
    if (rst_i || sleep_n_pin_i)
      slp_q <= 16'h0;
    else if (slp_q != 16'hFFFF)
      slp_q <= slp_q + 16'h1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  pump_uv_a:
    assert property ((pump_undervolt_i && aw)[*6] |-> !switch_en_o && !fault_out_n_o)
      else $error("pump undervoltage ignored");
  pin_ovp_a:
    assert property ((ovp_high_trip_i && !serial_variant_i && aw)[*6] |-> !switch_en_o)
      else $error("pin variant overvoltage ignored");
  tsd_sw_a:
    assert property ((tsd_switch_i && aw)[*6] |-> !switch_en_o && !pump_en_o && !fault_out_n_o)
      else $error("switch sensor trip ignored");
  tsd_die_a:
    assert property ((tsd_die_i && aw)[*6] |-> !reg_en_o && !pump_en_o && !fault_out_n_o)
      else $error("die sensor trip ignored");
  sleep_off_a:
    assert property (slp_q > RST_MAX_CYC_P + 4 |-> !switch_en_o && !reg_en_o && fault_out_n_o)
      else $error("outputs active while asleep");
  ack_once_a:
    assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
  ack_resp_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
      else $error("request not answered");
  dat_idle_a:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
  cover property ($fell(switch_en_o));
  cover property ($fell(fault_out_n_o));
  cover property ($rose(wb_ack_o));
endmodule // mfm_fault_mgr_sva
bind mfm_fault_mgr mfm_fault_mgr_sva #(.RST_MAX_CYC_P(RST_MAX_CYC_P)) chk (.*);
`default_nettype wire

// ### test/test_mfm_fault_mgr.sv
// self-checking bench for the fault manager
// assumes the host model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module test_mfm_fault_mgr;
  import mfm_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0, serial_variant_i = 1'h0, pump_undervolt_i = 1'h0, ovp_low_trip_i = 1'h0;
  logic ovp_high_trip_i = 1'h0, reg_oc_i = 1'h0, thermal_warn_i = 1'h0, tsd_switch_i = 1'h0;
  logic tsd_die_i = 1'h0, spin = 1'h1, sleep_n_pin_i, wb_ack_o;
  logic switch_en_o, pump_en_o, reg_en_o, fault_out_n_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [3:0] sel_n = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  logic [5:0] oc_low_trip_i = 6'h00, oc_high_trip_i = 6'h00;
  logic [2:0] hall_i;
  logic [3:0] exp_pins [4] = '{4'h6, 4'h6, 4'hE, 4'hF};
  int failures = 0, n_tests = 0;
  // short retry, stall and pulse counts keep the run brief
  mfm_fault_mgr #(.OCP_RETRY_CYC_P(40), .REG_RETRY_CYC_P(40), .LOCK_RETRY_CYC_P(40),
    .LOCK_HW_CYC_P(90), .LOCK_T0_CYC_P(50), .LOCK_T1_CYC_P(60), .LOCK_T2_CYC_P(70),
    .LOCK_T3_CYC_P(80), .RST_MAX_CYC_P(20)) uut (.*);
  mfm_host host (.clk_i(clk_i), .spin_i(spin), .hall_o(hall_i), .sleep_n_o(sleep_n_pin_i));
  always #2 clk_i = ~clk_i;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one classic cycle; waits for ack, bounded by the watchdog
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_sel_i <= sel_n;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rdat, e);
  endtask
  // switch, pump, regulator, fault pin
  task automatic pins(input logic [3:0] e);
    chk({28'h0, switch_en_o, pump_en_o, reg_en_o, fault_out_n_o}, {28'h0, e});
  endtask
  task automatic print_verdict();
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    tick(20);
    rst_i <= 1'h0;
    tick(10);
    ovp_high_trip_i <= 1'h1;
    tick(8);
    pins(4'h6);
    ovp_high_trip_i <= 1'h0;
    tick(8);
    pins(4'hF);
    rd(ADR_STAT, 32'h5);
    // pin variant: low current level ignored, high level latches
    oc_low_trip_i <= 6'h01;
    tick(170);
    pins(4'hF);
    oc_high_trip_i <= 6'h20;
    tick(170);
    pins(4'h6);
    rd(ADR_STAT, 32'h2000D);
    oc_low_trip_i <= 6'h00;
    oc_high_trip_i <= 6'h00;
    host.pulse(5);
    tick(8);
    pins(4'hF);
    rd(ADR_STAT, 32'h0);
    rst_i <= 1'h1;
    serial_variant_i <= 1'h1;
    tick(20);
    rst_i <= 1'h0;
    tick(10);
    rd(ADR_CFG, 32'h0);
    rd(ADR_STAT, 32'h400);
    rd(8'h0C, 32'h0);
    ovp_low_trip_i <= 1'h1;
    tick(8);
    pins(4'hF);
    bus(1'h1, ADR_CFG, 32'h1);
    tick(8);
    pins(4'h6);
    bus(1'h1, ADR_CFG, 32'h3);
    tick(8);
    pins(4'hF);
    ovp_low_trip_i <= 1'h0;
    rd(ADR_STAT, 32'h405);
    bus(1'h1, ADR_CTRL, 32'h1);
    rd(ADR_STAT, 32'h400);
    bus(1'h1, ADR_CFG, 32'h0);
    // clock enable low freezes the pin path as well
    ce_i <= 1'h0;
    pump_undervolt_i <= 1'h1;
    tick(8);
    pins(4'hF);
    ce_i <= 1'h1;
    tick(8);
    pins(4'h6);
    pump_undervolt_i <= 1'h0;
    tick(8);
    pins(4'hF);
    rd(ADR_STAT, 32'h403);
    host.pulse(5);
    tick(8);
    rd(ADR_STAT, 32'h400);
    // overcurrent modes, then stall modes
    for (int k = 0; k < 8; k++)
    begin
      bus(1'h1, ADR_CFG, 32'(k % 4) << (k < 4 ? 2 : 6));
      if (k < 4)
        oc_low_trip_i <= 6'h04;
      else
        spin <= 1'h0;
      tick(k < 4 ? 100 : 30);
      pins(4'hF);
      tick(k < 4 ? 70 : 40);
      pins(exp_pins[k % 4]);
      rd(ADR_STAT, k % 4 == 3 ? 32'h400 : (k < 4 ? 32'h4409 : 32'h441));
      oc_low_trip_i <= 6'h00;
      spin <= 1'h1;
      tick(40);
      if (k == 0 || k == 4)
        pins(4'h6);
      if (k == 1)
        rd(ADR_STAT, 32'h4409);
      if (k == 5)
        rd(ADR_STAT, 32'h400);
      bus(1'h1, ADR_CTRL, 32'h1);
      tick(8);
      pins(4'hF);
    end
    // byte lane 1 only: low config byte must keep its value
    sel_n = 4'h2;
    bus(1'h1, ADR_CFG, 32'h401);
    sel_n = 4'hF;
    rd(ADR_CFG, 32'h4C0);
    bus(1'h1, ADR_CFG, 32'h400);
    thermal_warn_i <= 1'h1;
    tick(8);
    pins(4'hE);
    thermal_warn_i <= 1'h0;
    tsd_switch_i <= 1'h1;
    tick(8);
    pins(4'h2);
    tsd_switch_i <= 1'h0;
    tsd_die_i <= 1'h1;
    tick(8);
    pins(4'h0);
    tsd_die_i <= 1'h0;
    tick(8);
    pins(4'hF);
    rd(ADR_STAT, 32'h781);
    bus(1'h1, ADR_CTRL, 32'h1);
    rd(ADR_STAT, 32'h400);
    reg_oc_i <= 1'h1;
    tick(260);
    pins(4'hC);
    rd(ADR_STAT, 32'h431);
    reg_oc_i <= 1'h0;
    tick(50);
    rd(ADR_STAT, 32'h400);
    host.pulse(40);
    tick(10);
    rd(ADR_CFG, 32'h0);
    print_verdict();
  end
  initial
  begin
    tick(20000);
    failures++;
    print_verdict();
  end
endmodule // test_mfm_fault_mgr
`default_nettype wire
